// ===== rate_cfg_pkg.sv
`default_nettype none
package rate_cfg_pkg;

    // ========================================
    // Register map
    localparam logic [7:0] CFG_ADDR       = 8'h33;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam int         SEL_MSB        = 7;
    localparam int         SEL_LSB        = 2;
    localparam int         TOL_BIT        = 1;
    localparam int         RSVD_BIT       = 0;
    localparam logic       RSVD_VALUE     = 1'h0;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // ========================================
    // Rate codes
    localparam int         CODE_W         = 6;
    localparam logic [5:0] CODE_AUTO      = 6'h00;
    localparam logic [5:0] CODE_MAX       = 6'h28;
    localparam logic [5:0] SEL_RESET      = 6'h00;
    localparam logic       TOL_RESET      = 1'h0;

    // ========================================
    // Rate table entry, all values in Hz
    localparam int         RATE_W         = 20;
    localparam logic [19:0] RATE_ZERO     = 20'h00000;

    typedef struct packed {
        logic [19:0] nominal;
        logic [19:0] lo;
        logic [19:0] hi;
    } rate_entry_t;

    localparam rate_entry_t ENTRY_NONE = '{nominal: 20'h00000, lo: 20'h00000, hi: 20'h00000};

endpackage
`default_nettype wire

// ===== rate_lookup_if.sv
`default_nettype none
interface rate_lookup_if;
    import rate_cfg_pkg::*;

    logic [5:0]  code;
    rate_entry_t entry;

    modport requester (output code, input entry);
    modport table_side (input code, output entry);
endinterface
`default_nettype wire

// ===== rate_table_rom.sv
`default_nettype none
module rate_table_rom
    import rate_cfg_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    rate_lookup_if.table_side lookup
);

    // ========================================
    // Registered table read, one cycle of latency
    // Reserved and auto codes give an all-zero entry so no stale range survives
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lookup.entry <= ENTRY_NONE;
        end else begin
            unique case (lookup.code)
                6'h01: lookup.entry <= '{20'd768000, 20'd670320, 20'd791040};
                6'h02: lookup.entry <= '{20'd614400, 20'd536256, 20'd632832};
                6'h03: lookup.entry <= '{20'd512000, 20'd446880, 20'd527360};
                6'h04: lookup.entry <= '{20'd438857, 20'd383040, 20'd452022};
                6'h05: lookup.entry <= '{20'd384000, 20'd335160, 20'd395520};
                6'h06: lookup.entry <= '{20'd341333, 20'd297920, 20'd351573};
                6'h07: lookup.entry <= '{20'd307200, 20'd268128, 20'd316416};
                6'h08: lookup.entry <= '{20'd256000, 20'd223440, 20'd263680};
                6'h09: lookup.entry <= '{20'd219429, 20'd191520, 20'd226011};
                6'h0A: lookup.entry <= '{20'd192000, 20'd167580, 20'd197760};
                6'h0B: lookup.entry <= '{20'd170667, 20'd148960, 20'd175786};
                6'h0C: lookup.entry <= '{20'd153600, 20'd134064, 20'd158208};
                6'h0D: lookup.entry <= '{20'd128000, 20'd111720, 20'd131840};
                6'h0E: lookup.entry <= '{20'd109714, 20'd95760, 20'd113005};
                6'h0F: lookup.entry <= '{20'd96000, 20'd83790, 20'd98880};
                6'h10: lookup.entry <= '{20'd85333, 20'd74480, 20'd87893};
                6'h11: lookup.entry <= '{20'd76800, 20'd67032, 20'd79104};
                6'h12: lookup.entry <= '{20'd64000, 20'd55860, 20'd65920};
                6'h13: lookup.entry <= '{20'd54857, 20'd47880, 20'd56502};
                6'h14: lookup.entry <= '{20'd48000, 20'd41895, 20'd49440};
                6'h15: lookup.entry <= '{20'd42667, 20'd37240, 20'd43946};
                6'h16: lookup.entry <= '{20'd38400, 20'd33516, 20'd39552};
                6'h17: lookup.entry <= '{20'd32000, 20'd27930, 20'd32960};
                6'h18: lookup.entry <= '{20'd27429, 20'd23940, 20'd28251};
                6'h19: lookup.entry <= '{20'd24000, 20'd20947, 20'd24720};
                6'h1A: lookup.entry <= '{20'd21333, 20'd18620, 20'd21973};
                6'h1B: lookup.entry <= '{20'd19200, 20'd16758, 20'd19776};
                6'h1C: lookup.entry <= '{20'd16000, 20'd13965, 20'd16480};
                6'h1D: lookup.entry <= '{20'd13714, 20'd11970, 20'd14125};
                6'h1E: lookup.entry <= '{20'd12000, 20'd10473, 20'd12360};
                6'h1F: lookup.entry <= '{20'd10667, 20'd9310, 20'd10986};
                6'h20: lookup.entry <= '{20'd9600, 20'd8379, 20'd9888};
                6'h21: lookup.entry <= '{20'd8000, 20'd6982, 20'd8240};
                6'h22: lookup.entry <= '{20'd6857, 20'd5985, 20'd7062};
                6'h23: lookup.entry <= '{20'd6000, 20'd5236, 20'd6180};
                6'h24: lookup.entry <= '{20'd5333, 20'd4655, 20'd5493};
                6'h25: lookup.entry <= '{20'd4800, 20'd4189, 20'd4944};
                6'h26: lookup.entry <= '{20'd4000, 20'd3491, 20'd4120};
                6'h27: lookup.entry <= '{20'd3429, 20'd2992, 20'd3531};
                6'h28: lookup.entry <= '{20'd3000, 20'd2618, 20'd3090}; // Lowest rate
                default: lookup.entry <= ENTRY_NONE;                    // Auto or reserved
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== secondary_port_rate_config.sv
// Functional notes
// [R1] Config register sits at address 0x33 and every bit resets to zero.
// [R2] Bits 7..2 are a read/write rate code; zero means auto-detect the rate.
// [R3] Codes 1..40 pick fixed nominal rates with ranges; 1 is 768 kHz, 20 is 48 kHz.
// [R4] Code 40 is 3000 Hz, range 2618..3090; codes 41..63 are reserved.
// [R5] Bit 1 picks auto-match tolerance: clear 1 percent, set 5 percent; resets zero.
// [R6] Bit 0 is reserved, read only, always reads zero.
// [R7] Auto detection and tolerance act only in automatic clock configuration.
// [R8] A nonzero valid code overrides the detected rate with its nominal rate.
`default_nettype none
module secondary_port_rate_config
    import rate_cfg_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        custom_clk_cfg,
    input  wire logic        detect_valid,
    input  wire logic [19:0] detected_rate,
    output logic             auto_detect_enable,
    output logic             tolerance_5pct,
    output logic             rate_code_invalid,
    output logic      [19:0] secondary_rate,
    output logic      [19:0] rate_min,
    output logic      [19:0] rate_max,
    output logic             rate_in_range
);

    // ========================================
    // Register storage
    logic [5:0]  rate_select;
    logic        rate_tolerance;
    logic [5:0]  sel_q;
    logic [19:0] detected_q;
    logic        cfg_hit;
    logic        code_manual;
    logic        code_reserved;
    logic        auto_now;

    rate_lookup_if lookup ();

    assign cfg_hit = (reg_addr == CFG_ADDR);

    // Fields load on a write to the config address; bit 0 has no storage
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_select    <= SEL_RESET;                        // [R1]
            rate_tolerance <= TOL_RESET;                        // [R1]
        end else if (reg_wr && cfg_hit) begin
            rate_select    <= reg_wdata[SEL_MSB:SEL_LSB];      // [R2]
            rate_tolerance <= reg_wdata[TOL_BIT];               // [R5]
        end
    end

    // Registered read port; unmapped addresses read as zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= CFG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= cfg_hit ? {rate_select, rate_tolerance, RSVD_VALUE} // [R6]
                                 : UNMAPPED_READ;
        end
    end

    // ========================================
    // Rate table lookup
    // The code is delayed alongside the table so both stay aligned
    assign lookup.code = rate_select;

    rate_table_rom u_rate_table (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .lookup  (lookup)
    );

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q <= SEL_RESET;
        end else begin
            sel_q <= rate_select;
        end
    end

    // Last detected rate is held so a quiet detector keeps its answer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            detected_q <= RATE_ZERO;
        end else if (detect_valid) begin
            detected_q <= detected_rate;
        end
    end

    // ========================================
    // Effective rate selection
    assign code_manual   = (sel_q != CODE_AUTO) && (sel_q <= CODE_MAX);
    assign code_reserved = (sel_q > CODE_MAX);                          // [R4]
    assign auto_now      = (sel_q == CODE_AUTO) && !custom_clk_cfg;     // [R7]

    // Custom clocking leaves the rate to manual divider setup, so auto turns off
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            auto_detect_enable <= 1'h0;
            tolerance_5pct     <= 1'h0;
        end else begin
            auto_detect_enable <= auto_now;                              // [R2]
            tolerance_5pct     <= auto_now && rate_tolerance;            // [R5]
        end
    end

    // Reserved codes drive zero rather than guess a rate
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            secondary_rate    <= RATE_ZERO;
            rate_min          <= RATE_ZERO;
            rate_max          <= RATE_ZERO;
            rate_code_invalid <= 1'h0;
            rate_in_range     <= 1'h0;
        end else begin
            rate_code_invalid <= code_reserved;                          // [R4]
            rate_min          <= lookup.entry.lo;                        // [R3]
            rate_max          <= lookup.entry.hi;                        // [R3]
            if (code_manual) begin
                secondary_rate <= lookup.entry.nominal;                  // [R8]
                rate_in_range  <= (detected_q >= lookup.entry.lo) &&
                                  (detected_q <= lookup.entry.hi);       // [R3]
            end else if (auto_now) begin
                secondary_rate <= detected_q;                            // [R2]
                rate_in_range  <= 1'h0;
            end else begin
                secondary_rate <= RATE_ZERO;
                rate_in_range  <= 1'h0;
            end
        end
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_readback;
        (reg_wr && cfg_hit) ##1 (reg_rd && cfg_hit && !reg_wr) |=>
            reg_rdata[7:1] == $past(reg_wdata[7:1], 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // [R2]

    property p_rsvd_zero;
        reg_rd |=> !reg_rdata[RSVD_BIT];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("bit 0 read as one"); // [R6]

    property p_unmapped;
        (reg_rd && !cfg_hit) |=> reg_rdata == UNMAPPED_READ;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R1]

    property p_code1;
        (reg_wr && cfg_hit && reg_wdata[7:2] == 6'h01) ##1 (!reg_wr)[*2] |=>
            secondary_rate == 20'd768000 && rate_min == 20'd670320 && rate_max == 20'd791040;
    endproperty
    a_code1: assert property (p_code1) else $error("code 1 rate wrong"); // [R3]

    property p_code20;
        (reg_wr && cfg_hit && reg_wdata[7:2] == 6'h14) ##1 (!reg_wr)[*2] |=>
            secondary_rate == 20'd48000;
    endproperty
    a_code20: assert property (p_code20) else $error("code 20 rate wrong"); // [R3]

    property p_code40;
        (reg_wr && cfg_hit && reg_wdata[7:2] == 6'h28) ##1 (!reg_wr)[*2] |=>
            secondary_rate == 20'd3000 && rate_min == 20'd2618 && rate_max == 20'd3090;
    endproperty
    a_code40: assert property (p_code40) else $error("code 40 rate wrong"); // [R4]

    property p_reserved;
        (reg_wr && cfg_hit && reg_wdata[7:2] > CODE_MAX) ##1 (!reg_wr)[*2] |=>
            rate_code_invalid && secondary_rate == RATE_ZERO && !auto_detect_enable;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code accepted"); // [R4]

    property p_auto_on;
        (reg_wr && cfg_hit && reg_wdata[7:2] == CODE_AUTO && reg_wdata[TOL_BIT])
            ##1 (!reg_wr && !custom_clk_cfg)[*2] |=> auto_detect_enable && tolerance_5pct;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("auto mode not entered"); // [R5]

    property p_custom_blocks;
        custom_clk_cfg |=> !auto_detect_enable && !tolerance_5pct;
    endproperty
    a_custom_blocks: assert property (p_custom_blocks) else $error("auto in custom mode"); // [R7]

    property p_manual_holds;
        (reg_wr && cfg_hit && reg_wdata[7:2] == 6'h21) ##1 (!reg_wr)[*4] |->
            secondary_rate == 20'd8000 && !auto_detect_enable;
    endproperty
    a_manual_holds: assert property (p_manual_holds) else $error("manual rate lost"); // [R8]

    // Tolerance output is gated by auto mode, so it never stands alone
    property p_tol_needs_auto;
        tolerance_5pct |-> auto_detect_enable;
    endproperty
    a_tol_needs_auto: assert property (p_tol_needs_auto) else $error("tolerance outside auto"); // [R5]

    // A reserved code must not leave a stale range behind
    property p_reserved_outputs;
        rate_code_invalid |->
            !auto_detect_enable && rate_min == RATE_ZERO && rate_max == RATE_ZERO;
    endproperty
    a_reserved_outputs: assert property (p_reserved_outputs) else $error("reserved range kept"); // [R4]

    // Range matching belongs to manual codes only
    property p_auto_no_range;
        auto_detect_enable |-> !rate_in_range;
    endproperty
    a_auto_no_range: assert property (p_auto_no_range) else $error("range flag in auto"); // [R8]

    // A report taken in auto mode reaches the rate output two edges later
    property p_auto_rate;
        detect_valid ##2 auto_detect_enable |-> secondary_rate == $past(detected_rate, 2);
    endproperty
    a_auto_rate: assert property (p_auto_rate) else $error("auto rate not forwarded"); // [R2]

    // Main scenarios: auto report, manual match, reserved code, wide tolerance, custom
    c_auto_rate:  cover property (auto_detect_enable && detect_valid ##2 secondary_rate != 0);
    c_custom:     cover property (custom_clk_cfg && !auto_detect_enable);
    c_manual:     cover property (secondary_rate == 20'd48000 && rate_in_range);
    c_reserved:   cover property (rate_code_invalid);
    c_tol5:       cover property (tolerance_5pct);

endmodule
`default_nettype wire

// ===== rate_source_model.sv
`default_nettype none
// ========================================
// Far-side rate detector model: reports a measured frame rate on request
module rate_source_model (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        send,
    input  wire logic [19:0] send_rate,
    input  wire logic        slow,
    output logic             detect_valid,
    output logic      [19:0] detected_rate
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0]  wait_cnt;
    logic [19:0] held;
    logic        pending;

    // One-cycle report, either at once or after a few idle cycles
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pending      <= 1'b0;
            wait_cnt     <= 2'h0;
            held         <= 20'h00000;
            detect_valid <= 1'b0;
        end else begin
            detect_valid <= 1'b0;
            if (send) begin
                pending  <= 1'b1;
                held     <= send_rate;
                wait_cnt <= slow ? 2'h3 : 2'h0;
            end else if (pending && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (pending) begin
                pending      <= 1'b0;
                detect_valid <= 1'b1;
            end
        end
    end

    // Outside the valid cycle show garbage so a stale sample cannot pass
    assign detected_rate = detect_valid ? held : ~held;
endmodule
`default_nettype wire

// ===== secondary_port_rate_config_tb.sv
`default_nettype none
module secondary_port_rate_config_tb import rate_cfg_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic        custom_clk_cfg = 1'b0;
    logic        send = 1'b0;
    logic [19:0] send_rate = 20'h00000;
    logic        slow = 1'b0;
    logic [7:0]  reg_rdata;
    logic        detect_valid;
    logic [19:0] detected_rate;
    logic        auto_detect_enable;
    logic        tolerance_5pct;
    logic        rate_code_invalid;
    logic [19:0] secondary_rate;
    logic [19:0] rate_min;
    logic [19:0] rate_max;
    logic        rate_in_range;
    int          err_count = 0;
    int          comparisons = 0;
    int          seed = 32'h24BC9D50;
    logic [5:0]  codes [8] = '{6'h01, 6'h02, 6'h14, 6'h21, 6'h27, 6'h28, 6'h29, 6'h3F};

    secondary_port_rate_config uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .custom_clk_cfg(custom_clk_cfg), .detect_valid(detect_valid),
        .detected_rate(detected_rate), .auto_detect_enable(auto_detect_enable),
        .tolerance_5pct(tolerance_5pct), .rate_code_invalid(rate_code_invalid),
        .secondary_rate(secondary_rate), .rate_min(rate_min), .rate_max(rate_max),
        .rate_in_range(rate_in_range));
    rate_source_model far_side (.mclk(mclk), .sys_rst(sys_rst), .send(send),
        .send_rate(send_rate), .slow(slow), .detect_valid(detect_valid),
        .detected_rate(detected_rate));

    always #4 mclk = ~mclk;

    // ========================================
    // Shared helpers
    task automatic check_val(input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Waits past the three-cycle path from write to rate outputs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    task automatic detect(input logic [19:0] r, input logic s);
        @(posedge mclk);
        send <= 1'b1;
        send_rate <= r;
        slow <= s;
        @(posedge mclk);
        send <= 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
    endtask

    // Only a handful of table rows are held here, enough for both ends and the middle
    function automatic rate_entry_t exp_entry(input logic [5:0] code);
        case (code)
            6'h01: exp_entry = '{20'hBB800, 20'hA3A70, 20'hC1200};
            6'h02: exp_entry = '{20'h96000, 20'h82EC0, 20'h9A800};
            6'h14: exp_entry = '{20'h0BB80, 20'h0A3A7, 20'h0C120};
            6'h21: exp_entry = '{20'h01F40, 20'h01B46, 20'h02030};
            6'h27: exp_entry = '{20'h00D65, 20'h00BB0, 20'h00DCB};
            6'h28: exp_entry = '{20'h00BB8, 20'h00A3A, 20'h00C12};
            default: exp_entry = ENTRY_NONE;
        endcase
    endfunction

    task automatic check_code(input logic [5:0] code);
        rate_entry_t e;
        e = exp_entry(code);
        check_val(secondary_rate, e.nominal);
        check_val(rate_min, e.lo);
        check_val(rate_max, e.hi);
        check_val(20'(rate_code_invalid), 20'(code > CODE_MAX));
        check_val(20'(auto_detect_enable), 20'h00000);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        give_verdict();
    end

    // ========================================
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [5:0] c;
        logic       t;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(CFG_ADDR, d);
        check_val(20'(d), 20'(CFG_RESET));
        check_val(20'(auto_detect_enable), 20'h00001);
        $display("test reset done");
        foreach (codes[i]) begin
            wr(CFG_ADDR, {codes[i], 2'b00});
            check_code(codes[i]);
        end
        $display("test rate table done");
        wr(CFG_ADDR, 8'h50);
        detect(20'h0AFC8, 1'b0);
        check_val(secondary_rate, 20'h0BB80);
        check_val(20'(rate_in_range), 20'h00001);
        detect(20'h0C350, 1'b1);
        check_val(20'(rate_in_range), 20'h00000);
        $display("test manual range done");
        wr(CFG_ADDR, 8'h02);
        detect(20'h0AC44, 1'b1);
        check_val(secondary_rate, 20'h0AC44);
        check_val(20'(tolerance_5pct), 20'h00001);
        @(posedge mclk);
        custom_clk_cfg <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check_val(20'(auto_detect_enable), 20'h00000);
        check_val(20'(tolerance_5pct), 20'h00000);
        check_val(secondary_rate, RATE_ZERO);
        @(posedge mclk);
        custom_clk_cfg <= 1'b0;
        $display("test auto mode done");
        wr(8'h32, 8'hFF);
        rd(8'h32, d);
        check_val(20'(d), 20'(UNMAPPED_READ));
        rd(CFG_ADDR, d);
        check_val(20'(d), 20'h00002);
        wr(CFG_ADDR, 8'h51);
        rd(CFG_ADDR, d);
        check_val(20'(d), 20'h00050);
        $display("test address and reserved bit done");
        // Random host traffic keeps to legal codes and a zero reserved bit
        repeat (20) begin
            c = 6'($unsigned($random(seed)) % 41);
            t = 1'($random(seed));
            wr(CFG_ADDR, {c, t, 1'b0});
            rd(CFG_ADDR, d);
            check_val(20'(d), 20'({c, t, 1'b0}));
            check_val(20'(rate_code_invalid), 20'h00000);
            check_val(20'(auto_detect_enable), 20'(c == CODE_AUTO));
            check_val(20'(tolerance_5pct), 20'(c == CODE_AUTO && t));
        end
        // Read right behind a write must already see the new value
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= CFG_ADDR;
        reg_wdata <= 8'h54;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check_val(20'(reg_rdata), 20'h00054);
        $display("test random writes done");
        give_verdict();
    end
endmodule
`default_nettype wire
